// [include/vel_pkg.sv]
// Purpose: Constants and types for the encoder level/mode register group
// Assumes: Registers are written over the serial control port
// Notes:   Subaddresses are byte addresses of that port
package vel_pkg;

  // Device address on the control port; arbitrary value
  localparam logic [6:0] VEL_DEV_ADDR = 7'h2a;

  localparam logic [7:0] SA_V_GAIN_LO     = 8'h5c;
  localparam logic [7:0] SA_V_GAIN_MSB    = 8'h5e;
  localparam logic [7:0] SA_CROSS_VBLANK  = 8'h5f;
  localparam logic [7:0] SA_STD_CONTROL   = 8'h61;
  localparam logic [7:0] SA_SUBC_BURST    = 8'h62;

  localparam int          REG_COUNT = 5;
  localparam logic [2:0] IX_V_GAIN_LO    = 3'h0;
  localparam logic [2:0] IX_V_GAIN_MSB   = 3'h1;
  localparam logic [2:0] IX_CROSS_VBLANK = 3'h2;
  localparam logic [2:0] IX_STD_CONTROL  = 3'h3;
  localparam logic [2:0] IX_SUBC_BURST   = 3'h4;
  localparam logic [2:0] IX_NONE         = 3'h7;

  localparam logic [7:0] RST_V_GAIN_LO    = 8'h00;
  localparam logic [7:0] RST_V_GAIN_MSB   = 8'h35;
  localparam logic [7:0] RST_CROSS_VBLANK = 8'h00;
  localparam logic [7:0] RST_STD_CONTROL  = 8'h86;
  localparam logic [7:0] RST_SUBC_BURST   = 8'h2f;

  // Field positions
  localparam int BIT_V_GAIN_MSB   = 7;
  localparam int BIT_PHASE_EN     = 6;
  localparam int BIT_CCR_HI       = 7;
  localparam int BIT_CCR_LO       = 6;
  localparam int BIT_RGB_DOWN     = 7;
  localparam int BIT_CVBS_DOWN    = 6;
  localparam int BIT_PAL_INVERT   = 5;
  localparam int BIT_LUMA_GAIN    = 4;
  localparam int BIT_SECAM        = 3;
  localparam int BIT_CHROMA_BW    = 2;
  localparam int BIT_PAL          = 1;
  localparam int BIT_LINE_LENGTH  = 0;
  localparam int BIT_RT_SUBC      = 7;

  typedef struct packed {
    logic [8:0] chroma_v_gain;
    logic       realtime_control_input_phase_reset_enable;
    logic [5:0] blanking_level;
    logic       cross_color_filter_select_hi;
    logic       cross_color_filter_select_lo;
    logic [5:0] vertical_blanking_level;
    logic       rgb_dac_down;
    logic       composite_dac_down;
    logic       pal_switch_invert;
    logic       luma_gain_select;
    logic       secam_enable;
    logic       chroma_bandwidth_select;
    logic       pal_select;
    logic       line_length_select;
    logic       realtime_subcarrier_enable;
    logic [6:0] burst_amplitude;
  } vel_ctrl_t;

  typedef enum logic [2:0] {
    VEL_IDLE = 3'b000,
    VEL_ADDR = 3'b001,
    VEL_SUB  = 3'b011,
    VEL_WR   = 3'b010,
    VEL_RD   = 3'b110
  } vel_state_t;

endpackage

// [src/vel_regs.sv]
// Purpose: Level and mode control registers of a video encoder
// Assumes: Serial control port pins are asynchronous; line_start_i is a
//          one-cycle pulse from the encoder timing on core_clk_i
// Notes:   Settings reach the datapath only at a line start
// What this block does
// - Bit 7 of register 5Eh is the MSB of the 9-bit V gain.
// - Phase-enable bit gates the subcarrier phase reset flag from real-time input.
// - Blanking level field bits 5..0 sets output blanking level (140 IRE scale).
// - Same field under 143 IRE scale; blanking level resets to 35h.
// - Bits 7..6 of 5Fh pick the cross-colour reduction filter.
// - Bits 5..0 of 5Fh set the vertical blanking level.
// - RGB DAC down bit forces R, G, B DACs low; resets to 1.
// - Composite DAC down bit forces CVBS, Y, C DACs low; resets to 0.
// - PAL switch invert flips PAL phase only with real-time control enabled.
// - Luma gain select: 0 is 100 IRE, 1 is 92.5 with set-up.
// - SECAM bit enables SECAM, resets 0; host clears PAL bit then.
// - Chroma bandwidth bit: 0 enlarged, 1 standard; resets to 1.
// - PAL bit: 1 PAL (reset), 0 NTSC.
// - Line length bit: 0 gives 864 clocks (reset), 1 gives 858.
// - Real-time subcarrier enable takes frequency from external decoder; resets 0.
// - Burst amplitude field bits 6..0 sets colour burst amplitude.
// - Lower eight V gain bits live in a separate register.
// - Burst amplitude resets to 2Fh.
`timescale 1ns/1ns
module vel_regs
  import vel_pkg::*;
(
  input  wire logic      core_clk_i,
  input  wire logic      rst_n_i,
  input  wire logic      scl_i,
  input  wire logic      sda_i,
  output logic           sda_o,
  output logic           sda_oe_o,
  input  wire logic      line_start_i,
  input  wire logic      realtime_control_input_phase_reset_i,
  output vel_ctrl_t      ctrl_o,
  output logic           phase_reset_o,
  output logic           pal_phase_invert_o
);

  function automatic logic [2:0] index_of(input logic [7:0] sa);
    case (sa)
      SA_V_GAIN_LO:    index_of = IX_V_GAIN_LO;
      SA_V_GAIN_MSB:   index_of = IX_V_GAIN_MSB;
      SA_CROSS_VBLANK: index_of = IX_CROSS_VBLANK;
      SA_STD_CONTROL:  index_of = IX_STD_CONTROL;
      SA_SUBC_BURST:   index_of = IX_SUBC_BURST;
      default:         index_of = IX_NONE;
    endcase
  endfunction

  logic [7:0] regs_q [REG_COUNT];
  logic [2:0] scl_sync_q;
  logic [2:0] sda_sync_q;
  logic [1:0] realtime_control_input_sync_q;
  vel_state_t state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic       ack_go_q;
  logic       sda_oe_q;
  vel_ctrl_t  ctrl_q;
  logic       phase_reset_q;
  logic       pal_inv_q;

  // Edges use the second and third stages only
  wire scl_s      = scl_sync_q[1];
  wire sda_s      = sda_sync_q[1];
  wire scl_rise   = scl_s & ~scl_sync_q[2];
  wire scl_fall   = ~scl_s & scl_sync_q[2];
  wire start_det  = scl_s & scl_sync_q[2] & ~sda_s & sda_sync_q[2];
  wire stop_det   = scl_s & scl_sync_q[2] & sda_s & ~sda_sync_q[2];
  wire active     = (state_q != VEL_IDLE);
  wire [7:0] rx_byte  = {shift_q[6:0], sda_s};
  wire byte_done  = active & scl_rise & (bit_cnt_q == 4'h7);
  wire addr_hit   = (rx_byte[7:1] == VEL_DEV_ADDR);
  wire [2:0] ptr_ix   = index_of(ptr_q);
  wire wr_en      = byte_done & (state_q == VEL_WR);
  wire [7:0] rd_byte  = (ptr_ix == IX_NONE) ? 8'h00 : regs_q[ptr_ix];
  wire master_nack = active & scl_rise & (bit_cnt_q == 4'h8) &
                     (state_q == VEL_RD) & sda_s;

  // Byte lanes of the applied control set
  vel_ctrl_t ctrl_d;
  assign ctrl_d.chroma_v_gain = {regs_q[IX_V_GAIN_MSB][BIT_V_GAIN_MSB],
                                 regs_q[IX_V_GAIN_LO]};
  assign ctrl_d.realtime_control_input_phase_reset_enable =
    regs_q[IX_V_GAIN_MSB][BIT_PHASE_EN];
  assign ctrl_d.blanking_level = regs_q[IX_V_GAIN_MSB][5:0];
  assign ctrl_d.cross_color_filter_select_hi =
    regs_q[IX_CROSS_VBLANK][BIT_CCR_HI];
  assign ctrl_d.cross_color_filter_select_lo =
    regs_q[IX_CROSS_VBLANK][BIT_CCR_LO];
  assign ctrl_d.vertical_blanking_level =
    regs_q[IX_CROSS_VBLANK][5:0];
  assign ctrl_d.rgb_dac_down = regs_q[IX_STD_CONTROL][BIT_RGB_DOWN];
  assign ctrl_d.composite_dac_down =
    regs_q[IX_STD_CONTROL][BIT_CVBS_DOWN];
  assign ctrl_d.pal_switch_invert = regs_q[IX_STD_CONTROL][BIT_PAL_INVERT];
  assign ctrl_d.luma_gain_select =
    regs_q[IX_STD_CONTROL][BIT_LUMA_GAIN];
  assign ctrl_d.secam_enable = regs_q[IX_STD_CONTROL][BIT_SECAM];
  assign ctrl_d.chroma_bandwidth_select =
    regs_q[IX_STD_CONTROL][BIT_CHROMA_BW];
  assign ctrl_d.pal_select = regs_q[IX_STD_CONTROL][BIT_PAL];
  assign ctrl_d.line_length_select =
    regs_q[IX_STD_CONTROL][BIT_LINE_LENGTH];
  assign ctrl_d.realtime_subcarrier_enable =
    regs_q[IX_SUBC_BURST][BIT_RT_SUBC];
  assign ctrl_d.burst_amplitude = regs_q[IX_SUBC_BURST][6:0];

  wire phase_reset_d = ctrl_q.realtime_control_input_phase_reset_enable &
                       realtime_control_input_sync_q[1];
  wire pal_inv_d     = ctrl_q.pal_switch_invert &
                       ctrl_q.realtime_subcarrier_enable;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      scl_sync_q  <= 3'h7;
      sda_sync_q  <= 3'h7;
      realtime_control_input_sync_q <= 2'h0;
    end else begin
      scl_sync_q  <= {scl_sync_q[1:0], scl_i};
      sda_sync_q  <= {sda_sync_q[1:0], sda_i};
      realtime_control_input_sync_q <= {realtime_control_input_sync_q[0], realtime_control_input_phase_reset_i};
    end
  end

  // Control port: address, subaddress, then auto-incrementing data
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_q   <= VEL_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      tx_q      <= 8'h00;
      ptr_q     <= 8'h00;
      ack_go_q  <= 1'b0;
      sda_oe_q  <= 1'b0;
    end else if (start_det) begin
      state_q   <= VEL_ADDR;
      bit_cnt_q <= 4'h0;
      sda_oe_q  <= 1'b0;
    end else if (stop_det) begin
      state_q  <= VEL_IDLE;
      sda_oe_q <= 1'b0;
    end else if (active && scl_rise) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
      if (bit_cnt_q < 4'h8) begin
        shift_q <= rx_byte;
      end
      if (master_nack) begin
        state_q <= VEL_IDLE;
      end
      if (byte_done) begin
        case (state_q)
          VEL_ADDR: begin
            ack_go_q <= addr_hit;
            if (!addr_hit) begin
              state_q <= VEL_IDLE;
            end else if (rx_byte[0]) begin
              state_q <= VEL_RD;
            end else begin
              state_q <= VEL_SUB;
            end
          end
          VEL_SUB: begin
            ptr_q    <= rx_byte;
            ack_go_q <= 1'b1;
            state_q  <= VEL_WR;
          end
          VEL_WR: begin
            ptr_q    <= ptr_q + 8'h01;
            ack_go_q <= 1'b1;
          end
          VEL_RD:  ack_go_q <= 1'b0;
          default: ack_go_q <= 1'b0;
        endcase
      end
    end else if (active && scl_fall) begin
      if (bit_cnt_q == 4'h8) begin
        sda_oe_q <= ack_go_q;
      end else if (bit_cnt_q == 4'h9) begin
        bit_cnt_q <= 4'h0;
        if (state_q == VEL_RD) begin
          tx_q     <= rd_byte;
          ptr_q    <= ptr_q + 8'h01;
          sda_oe_q <= ~rd_byte[7];
        end else begin
          sda_oe_q <= 1'b0;
        end
      end else if (state_q == VEL_RD && bit_cnt_q != 4'h0) begin
        // Open drain: a zero bit is driven, a one is released
        sda_oe_q <= ~tx_q[3'h7 - bit_cnt_q[2:0]];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      regs_q[IX_V_GAIN_LO]    <= RST_V_GAIN_LO;
      regs_q[IX_V_GAIN_MSB]   <= RST_V_GAIN_MSB;
      regs_q[IX_CROSS_VBLANK] <= RST_CROSS_VBLANK;
      regs_q[IX_STD_CONTROL]  <= RST_STD_CONTROL;
      regs_q[IX_SUBC_BURST]   <= RST_SUBC_BURST;
    end else if (wr_en && ptr_ix != IX_NONE) begin
      // SECAM with PAL still set is stored as written
      regs_q[ptr_ix] <= rx_byte;
    end
  end

  // Apply whole set at a line boundary so no line mixes settings
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ctrl_q        <= '0;
      phase_reset_q <= 1'b0;
      pal_inv_q     <= 1'b0;
    end else begin
      if (line_start_i) begin
        ctrl_q <= ctrl_d;
      end
      phase_reset_q <= phase_reset_d;
      pal_inv_q     <= pal_inv_d;
    end
  end

  assign sda_o              = 1'b0;
  assign sda_oe_o           = sda_oe_q;
  assign ctrl_o             = ctrl_q;
  assign phase_reset_o      = phase_reset_q;
  assign pal_phase_invert_o = pal_inv_q;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_reset_vals;
    $rose(rst_n_i) |-> regs_q[IX_V_GAIN_MSB] == RST_V_GAIN_MSB &&
      regs_q[IX_STD_CONTROL] == RST_STD_CONTROL &&
      regs_q[IX_SUBC_BURST] == RST_SUBC_BURST;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("register reset values wrong");

  property p_apply;
    line_start_i |=> ctrl_q == $past(ctrl_d);
  endproperty
  a_apply: assert property (p_apply)
    else $error("settings not applied at line start");

  property p_hold;
    !line_start_i |=> $stable(ctrl_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("settings changed mid line");

  property p_vgain;
    line_start_i |=> ctrl_q.chroma_v_gain ==
      {$past(regs_q[IX_V_GAIN_MSB][7]), $past(regs_q[IX_V_GAIN_LO])};
  endproperty
  a_vgain: assert property (p_vgain)
    else $error("v gain assembled wrongly");

  property p_phase;
    !ctrl_q.realtime_control_input_phase_reset_enable ##1 !line_start_i |-> !phase_reset_o;
  endproperty
  a_phase: assert property (p_phase)
    else $error("phase reset passed while disabled");

  property p_phase_src;
    phase_reset_o |-> $past(ctrl_q.realtime_control_input_phase_reset_enable) &&
      $past(realtime_control_input_sync_q[1]);
  endproperty
  a_phase_src: assert property (p_phase_src)
    else $error("phase reset without enabled flag");

  property p_palinv;
    pal_phase_invert_o |-> $past(ctrl_q.realtime_subcarrier_enable) &&
      $past(ctrl_q.pal_switch_invert);
  endproperty
  a_palinv: assert property (p_palinv)
    else $error("pal invert without real-time control");

  property p_write_ctl;
    wr_en && ptr_ix == IX_STD_CONTROL |=>
      regs_q[IX_STD_CONTROL] == $past(rx_byte);
  endproperty
  a_write_ctl: assert property (p_write_ctl)
    else $error("control write lost");

  property p_stop;
    stop_det && !start_det |=> state_q == VEL_IDLE && !sda_oe_o;
  endproperty
  a_stop: assert property (p_stop)
    else $error("port not idle after stop");

  c_write: cover property (wr_en && ptr_ix == IX_STD_CONTROL);
  c_read: cover property (state_q == VEL_RD && scl_fall);
  c_apply: cover property (line_start_i && ctrl_d != ctrl_q);
  c_phase: cover property (phase_reset_o);

endmodule // vel_regs

// [test/tb_vel_regs.sv]
// Purpose: Self-checking bench for the encoder level/mode registers
// Assumes: Bench is the control port master; SDA has a pull-up
// Notes:   Checks read-back, applied settings per line and status outputs
`timescale 1ns/1ns
module tb_vel_regs;
  import vel_pkg::*;
  logic       core_clk_i;
  logic       rst_n_i;
  logic       scl;
  logic       sda_m;
  logic       line_start;
  logic       realtime_control_input;
  logic       sda_o;
  logic       sda_oe_o;
  logic       phase_reset_o;
  logic       pal_phase_invert_o;
  vel_ctrl_t  ctrl_o;
  vel_ctrl_t  app;
  vel_ctrl_t  old;
  logic [7:0] m [0:6];
  logic [7:0] bf [0:8];
  int         n_mismatch;
  int         total_checks;
  // Open-drain wire: low if either party pulls it
  wire        sda_line = sda_m & (sda_oe_o ? sda_o : 1'b1);

  vel_regs vel_regs_i (
    .core_clk_i         (core_clk_i),
    .rst_n_i            (rst_n_i),
    .scl_i              (scl),
    .sda_i              (sda_line),
    .sda_o              (sda_o),
    .sda_oe_o           (sda_oe_o),
    .line_start_i       (line_start),
    .realtime_control_input_phase_reset_i (realtime_control_input),
    .ctrl_o             (ctrl_o),
    .phase_reset_o      (phase_reset_o),
    .pal_phase_invert_o (pal_phase_invert_o)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  task automatic report_and_stop();
    $display("mismatches %0d checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [39:0] e,
                     input logic [39:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Expected applied settings, built field by field from the model
  function automatic vel_ctrl_t exp_ctrl();
    vel_ctrl_t c;
    c.chroma_v_gain = {m[2][7], m[0]};
    c.realtime_control_input_phase_reset_enable = m[2][6];
    c.blanking_level = m[2][5:0];
    {c.cross_color_filter_select_hi, c.cross_color_filter_select_lo,
     c.vertical_blanking_level} = m[3];
    {c.rgb_dac_down, c.composite_dac_down, c.pal_switch_invert,
     c.luma_gain_select, c.secam_enable, c.chroma_bandwidth_select,
     c.pal_select, c.line_length_select} = m[5];
    {c.realtime_subcarrier_enable, c.burst_amplitude} = m[6];
    return c;
  endfunction

  // Quarter bit: keeps SCL phases at 6 core cycles, above the minimum
  task automatic qb();
    repeat (3) @(negedge core_clk_i);
  endtask

  task automatic bitx(input logic b, output logic r);
    qb();
    sda_m = b;
    qb();
    scl = 1'b1;
    qb();
    qb();
    r = sda_line;
    scl = 1'b0;
  endtask

  task automatic start();
    qb();
    sda_m = 1'b0;
    qb();
    scl = 1'b0;
  endtask

  task automatic stop();
    qb();
    sda_m = 1'b0;
    qb();
    scl = 1'b1;
    qb();
    sda_m = 1'b1;
    qb();
  endtask

  task automatic wbyte(input logic [7:0] b, input logic ea);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(b[i], r);
    bitx(1'b1, r);
    chk("ack", 40'(ea), 40'(r));
  endtask

  // Unmapped places are acked but dropped, so the model skips them
  task automatic wr(input logic [7:0] sa, input int n);
    int a;
    start();
    wbyte({VEL_DEV_ADDR, 1'b0}, 1'b0);
    wbyte(sa, 1'b0);
    for (int i = 0; i < n; i++) begin
      wbyte(bf[i], 1'b0);
      a = int'(sa) + i - 'h5c;
      if (a != 1 && a != 4) m[a] = bf[i];
    end
    stop();
  endtask

  task automatic rd(input logic [7:0] sa, input int n);
    logic [7:0] d;
    logic       r;
    start();
    wbyte({VEL_DEV_ADDR, 1'b0}, 1'b0);
    wbyte(sa, 1'b0);
    stop();
    start();
    wbyte({VEL_DEV_ADDR, 1'b1}, 1'b0);
    for (int i = 0; i < n; i++) begin
      for (int j = 0; j < 8; j++) begin
        bitx(1'b1, r);
        d = {d[6:0], r};
      end
      bitx(i == n - 1, r);
      chk("readback", 40'(m[int'(sa) + i - 'h5c]), 40'(d));
    end
    stop();
  endtask

  task automatic ls();
    @(negedge core_clk_i);
    line_start = 1'b1;
    @(negedge core_clk_i);
    line_start = 1'b0;
    @(negedge core_clk_i);
    app = exp_ctrl();
  endtask

  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
    line_start = 1'b0;
    realtime_control_input = 1'b0;
    rst_n_i = 1'b0;
    n_mismatch = 0;
    total_checks = 0;
    m = '{8'h00, 8'h00, 8'h35, 8'h00, 8'h00, 8'h86, 8'h2f};
    void'($urandom(32'ha906));
    repeat (4) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    chk("ctrl_reset", 40'h0, 40'(ctrl_o));
    rd(8'h5c, 7);
    ls();
    chk("ctrl", 40'(app), 40'(ctrl_o));
    // Recommended blanking codes with every filter choice
    for (int k = 0; k < 4; k++) begin
      bf[0] = {k[0], 1'b0, (k[1] ? 6'h2e : 6'h35)};
      bf[1] = {k[1:0], 6'h3f - 6'(k)};
      wr(8'h5e, 2);
      ls();
      chk("ctrl_ccr", 40'(app), 40'(ctrl_o));
    end
    for (int r = 0; r < 6; r++) begin
      for (int i = 0; i < 7; i++) bf[i] = 8'($urandom);
      if (bf[5][3]) bf[5][1] = 1'b0;
      old = app;
      wr(8'h5c, 7);
      chk("ctrl_hold", 40'(old), 40'(ctrl_o));
      rd(8'h5c, 7);
      ls();
      chk("ctrl", 40'(app), 40'(ctrl_o));
    end
    // Phase reset gating and PAL switch inversion for all enable pairs
    for (int k = 0; k < 4; k++) begin
      bf[0] = {1'b0, k[0], 6'h2e};
      wr(8'h5e, 1);
      bf[0] = {2'b00, k[1], 5'h02};
      bf[1] = {k[0], 7'h2f};
      wr(8'h61, 2);
      ls();
      realtime_control_input = k[1];
      repeat (5) @(negedge core_clk_i);
      chk("phase_reset", 40'(k[0] & k[1]), 40'(phase_reset_o));
      chk("pal_invert", 40'(k[0] & k[1]), 40'(pal_phase_invert_o));
      realtime_control_input = 1'b0;
    end
    // Foreign device address must be ignored
    start();
    wbyte({VEL_DEV_ADDR ^ 7'h01, 1'b0}, 1'b1);
    stop();
    rd(8'h5c, 7);
    report_and_stop();
  end

  // Whole run is about 20k cycles
  initial begin
    repeat (90000) @(posedge core_clk_i);
    n_mismatch++;
    report_and_stop();
  end
endmodule // tb_vel_regs
